// file: verilog/pbps_selector.v
// Purpose: selects one active parameter bank out of eight by fixed priority
// Assumes: request pins are asynchronous; register port on SYS_CLK_I
// Notes: levels request on their edges, so a pulse-chosen bank is not stolen back
// Function
// [RULE1] Up to eight banks, exactly one active at any time.
// [RULE2] After reset only bank 1 enabled and active; logic idle meanwhile.
// [RULE3] With several banks enabled, requests and conditions drive activation.
// [RULE4] Override enable set: automatic requests ignored, only override bank applied.
// [RULE5] A request may be a single pulse or a sustained level.
// [RULE6] Priority fixed by index: bank 1 highest, bank 8 lowest.
// [RULE7] Simultaneous levels: highest-priority requested bank becomes active.
// [RULE8] A pulse-activated bank stays active until another bank is requested.
// [RULE9] Forced change needs target enabled and override enable set.
// [RULE10] Levels present when override clears take back bank selection.
// [RULE11] Override selection None or 1..8, default None, acts as pulse.
// [RULE12] Override cleared with no requests: last forced bank stays active.
// [RULE13] Override enable defaults off, holds until cleared, gates remote changes.
// [RULE14] Setting picks number of enabled banks; new banks load defaults.
// [RULE15] Remote selection None or 1..8; rejected if higher level held.
// [RULE16] Level on bank 1 blocks requests for every other bank.
// [RULE17] Level on bank k blocks all lower-priority bank requests.
// [RULE18] Level on bank 8 blocks nothing.
// [RULE19] Active bank readable as status, default bank 1.
// [RULE20] Time-stamped event on status changes, ON and OFF masked separately.
// [RULE21] Flag failures: not enabled, blocked by override, higher priority prevails.
// [RULE22] No accepted request: active index held; 3-bit code, 0 means bank 1.
// [RULE23] Same-cycle pulses resolved by priority; ignored under blocking levels.
`timescale 1ns/1ns
`include "pbps_defs.vh"
`default_nettype none

module pbps_selector
(
  // Clock and reset
  input wire SYS_CLK_I,
  input wire RST_I,
  // Bank request pins
  input wire [7:0] REQ_I,
  // Register port
  input wire [3:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // Bank consumers
  output reg [2:0] ACTIVE_BANK_O,
  output reg [7:0] ACTIVE_ONEHOT_O,
  output reg [7:0] BANK_ENABLE_O,
  output reg [7:0] BANK_INIT_O,
  // Status and events
  output reg [2:0] REQ_FAIL_O,
  output reg EVENT_O
);

  // Lowest set bit wins: bank 1 sits at bit 0
  function [7:0] pbps_first;
    input [7:0] v;
    integer i;
    reg hit;
    begin
      pbps_first = 8'h00;
      hit = 1'b0;
      for (i = 0; i < `PBPS_BANKS; i = i + 1)
      begin
        if (v[i] && !hit)
        begin
          pbps_first[i] = 1'b1;
          hit = 1'b1;
        end
      end
    end
  endfunction

  function [2:0] pbps_index;
    input [7:0] oh;
    integer i;
    begin
      pbps_index = 3'h0;
      for (i = 0; i < `PBPS_BANKS; i = i + 1)
      begin
        if (oh[i])
        begin
          pbps_index = i[2:0];
        end
      end
    end
  endfunction

  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] lvl_prev_reg;
  reg [2:0] used_reg;
  reg ovr_en_reg;
  reg ovr_prev_reg;
  reg [3:0] ovr_sel_reg;
  reg [3:0] rem_sel_reg;
  reg [27:0] on_mask_reg;
  reg [27:0] off_mask_reg;
  reg [27:0] evt_on_reg;
  reg [27:0] evt_off_reg;
  reg [31:0] evt_time_reg;
  reg [31:0] time_reg;
  reg [27:0] stat_prev_reg;

  wire [7:0] lvl;
  wire [7:0] rise;
  wire wr_ctrl;
  wire wr_ovr;
  wire wr_rem;
  wire wr_on;
  wire wr_off;
  wire ev_any;
  wire ovr_fall;
  wire [7:0] req;
  reg [7:0] blocked;
  reg [7:0] en_next;
  wire [7:0] cand;
  wire [7:0] win;
  wire ovr_wr;
  wire rem_wr;
  wire [2:0] ovr_idx;
  wire [2:0] rem_idx;
  wire ovr_ok;
  wire rem_ok;
  reg [2:0] act_next;
  reg [2:0] fail_next;
  wire [27:0] stat_now;
  wire [27:0] ev_on;
  wire [27:0] ev_off;
  integer k;

  // Request pins: second flop is the first one logic may look at
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      lvl_prev_reg <= 8'h00;
    end
    else
    begin
      sync1_reg <= REQ_I;
      sync2_reg <= sync1_reg;
      lvl_prev_reg <= sync2_reg;
    end
  end

  assign lvl = sync2_reg;
  assign rise = lvl & ~lvl_prev_reg; // see [RULE5]
  assign ovr_fall = ovr_prev_reg & ~ovr_en_reg;

  // A falling pin never re-requests, so a pulse-chosen bank keeps control after
  // its pulse ends; held levels only re-request when the override drops
  assign req = rise | (lvl & {8{ovr_fall}}); // see [RULE10] see [RULE8]

  // A held level blocks every lower bank; bank 8 has none below it
  always @*
  begin
    blocked = 8'h00;
    for (k = 1; k < `PBPS_BANKS; k = k + 1)
    begin
      blocked[k] = blocked[k - 1] | lvl[k - 1]; // see [RULE16] see [RULE17] see [RULE18]
    end
  end

  // Used count n enables banks 1 to n+1
  always @*
  begin
    en_next = 8'h00;
    for (k = 0; k < `PBPS_BANKS; k = k + 1)
    begin
      en_next[k] = (k[2:0] <= used_reg); // see [RULE14]
    end
  end

  assign cand = req & BANK_ENABLE_O & ~blocked & {8{~ovr_en_reg}}; // see [RULE4] see [RULE23]
  assign win = pbps_first(cand); // see [RULE6] see [RULE7]

  // Write strobes decoded once per register
  assign wr_ctrl = WR_I && (ADDR_I == `PBPS_ADDR_CTRL);
  assign wr_ovr = WR_I && (ADDR_I == `PBPS_ADDR_OVR_SEL);
  assign wr_rem = WR_I && (ADDR_I == `PBPS_ADDR_REM_SEL);
  assign wr_on = WR_I && (ADDR_I == `PBPS_ADDR_ON_MASK);
  assign wr_off = WR_I && (ADDR_I == `PBPS_ADDR_OFF_MASK);

  // Codes 1 to 8 name a bank; None and codes above 8 are stored but act on nothing
  assign ovr_wr = wr_ovr && (WDATA_I[3:0] != `PBPS_SEL_NONE)
    && (WDATA_I[3:0] <= `PBPS_SEL_MAX);
  assign rem_wr = wr_rem && (WDATA_I[3:0] != `PBPS_SEL_NONE)
    && (WDATA_I[3:0] <= `PBPS_SEL_MAX);
  assign ovr_idx = WDATA_I[2:0] - 3'h1;
  assign rem_idx = WDATA_I[2:0] - 3'h1;
  assign ovr_ok = ovr_en_reg && BANK_ENABLE_O[ovr_idx]; // see [RULE9]
  assign rem_ok = ovr_en_reg && BANK_ENABLE_O[rem_idx]
    && !blocked[rem_idx]; // see [RULE13] see [RULE15]

  // Next active bank and failure flags
  always @*
  begin
    act_next = ACTIVE_BANK_O; // see [RULE22] see [RULE8] see [RULE12]
    fail_next = 3'h0;
    if (!BANK_ENABLE_O[ACTIVE_BANK_O])
    begin
      act_next = `PBPS_ACT_RST;
    end
    else if (ovr_wr && ovr_ok)
    begin
      act_next = ovr_idx; // see [RULE11]
    end
    else if (rem_wr && rem_ok)
    begin
      act_next = rem_idx;
    end
    else if (|win)
    begin
      act_next = pbps_index(win); // see [RULE3]
    end
    // Bit 0: bank not enabled, bit 1: override state, bit 2: priority lost
    fail_next[0] = (|(req & ~BANK_ENABLE_O)) || (ovr_wr && !BANK_ENABLE_O[ovr_idx])
      || (rem_wr && !BANK_ENABLE_O[rem_idx]); // see [RULE21]
    fail_next[1] = (ovr_en_reg && (|req)) || (ovr_wr && !ovr_en_reg)
      || (rem_wr && !ovr_en_reg);
    fail_next[2] = (|(req & BANK_ENABLE_O & blocked)) || (|(cand & ~win))
      || (rem_wr && ovr_en_reg && blocked[rem_idx]);
  end

  // Status vector watched for events
  assign stat_now = {BANK_ENABLE_O, lvl, ovr_en_reg, REQ_FAIL_O, ACTIVE_ONEHOT_O};
  assign ev_on = stat_now & ~stat_prev_reg & on_mask_reg; // see [RULE20]
  assign ev_off = ~stat_now & stat_prev_reg & off_mask_reg;
  assign ev_any = (|ev_on) | (|ev_off);

  // Configuration registers written over the register port
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      used_reg <= `PBPS_USED_RST; // see [RULE2]
      ovr_en_reg <= 1'b0;
      ovr_prev_reg <= 1'b0;
      ovr_sel_reg <= `PBPS_SEL_NONE;
      rem_sel_reg <= `PBPS_SEL_NONE;
      on_mask_reg <= `PBPS_MASK_RST;
      off_mask_reg <= `PBPS_MASK_RST;
    end
    else
    begin
      ovr_prev_reg <= ovr_en_reg;
      if (wr_ctrl)
      begin
        used_reg <= WDATA_I[`PBPS_CTRL_USED_MSB:`PBPS_CTRL_USED_LSB];
        ovr_en_reg <= WDATA_I[`PBPS_CTRL_OVR_BIT]; // see [RULE13]
      end
      if (wr_ovr)
      begin
        ovr_sel_reg <= WDATA_I[3:0];
      end
      if (wr_rem)
      begin
        rem_sel_reg <= WDATA_I[3:0];
      end
      if (wr_on)
      begin
        on_mask_reg <= WDATA_I[27:0];
      end
      if (wr_off)
      begin
        off_mask_reg <= WDATA_I[27:0];
      end
    end
  end

  // Index and one-hot move together; the active bank returns to bank 1 one cycle after its enable drops
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ACTIVE_BANK_O <= `PBPS_ACT_RST;
      ACTIVE_ONEHOT_O <= `PBPS_ONEHOT_RST;
      BANK_ENABLE_O <= `PBPS_EN_RST;
      BANK_INIT_O <= 8'h00;
      REQ_FAIL_O <= 3'h0;
    end
    else
    begin
      // Consumers load default parameters into freshly enabled banks
      BANK_ENABLE_O <= en_next;
      BANK_INIT_O <= en_next & ~BANK_ENABLE_O; // see [RULE14]
      ACTIVE_BANK_O <= act_next; // see [RULE1]
      ACTIVE_ONEHOT_O <= 8'h01 << act_next;
      REQ_FAIL_O <= fail_next;
    end
  end

  // Event latches keep only the newest change; there is no queue behind them
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      evt_on_reg <= 28'h0000000;
      evt_off_reg <= 28'h0000000;
      evt_time_reg <= 32'h00000000;
      time_reg <= 32'h00000000;
      stat_prev_reg <= 28'h0000000;
      EVENT_O <= 1'b0;
    end
    else
    begin
      time_reg <= time_reg + 32'h00000001;
      stat_prev_reg <= stat_now;
      EVENT_O <= ev_any;
      if (ev_any)
      begin
        evt_on_reg <= ev_on;
        evt_off_reg <= ev_off;
        evt_time_reg <= time_reg;
      end
    end
  end

  // Read data stands in the cycle after the strobe
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      RDATA_O <= 32'h00000000;
    end
    else if (RD_I)
    begin
      case (ADDR_I)
        `PBPS_ADDR_CTRL:
        begin
          RDATA_O <= {28'h0000000, ovr_en_reg, used_reg};
        end
        `PBPS_ADDR_OVR_SEL:
        begin
          RDATA_O <= {28'h0000000, ovr_sel_reg};
        end
        `PBPS_ADDR_REM_SEL:
        begin
          RDATA_O <= {28'h0000000, rem_sel_reg};
        end
        `PBPS_ADDR_STATUS:
        begin
          RDATA_O <= {5'h00, REQ_FAIL_O, lvl, BANK_ENABLE_O,
            5'h00, ACTIVE_BANK_O}; // see [RULE19]
        end
        `PBPS_ADDR_ON_MASK:
        begin
          RDATA_O <= {4'h0, on_mask_reg};
        end
        `PBPS_ADDR_OFF_MASK:
        begin
          RDATA_O <= {4'h0, off_mask_reg};
        end
        `PBPS_ADDR_EVT_ON:
        begin
          RDATA_O <= {4'h0, evt_on_reg};
        end
        `PBPS_ADDR_EVT_OFF:
        begin
          RDATA_O <= {4'h0, evt_off_reg};
        end
        `PBPS_ADDR_EVT_TIME:
        begin
          RDATA_O <= evt_time_reg;
        end
        `PBPS_ADDR_TIME_NOW:
        begin
          RDATA_O <= time_reg;
        end
        default:
        begin
          RDATA_O <= 32'h00000000;
        end
      endcase
    end
    else
    begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule // pbps_selector
`default_nettype wire

// file: verilog/pbps_defs.vh
// Purpose: constants for the parameter bank priority selector
// Assumes: word-addressed register port, 10 MHz system clock
// Notes: definitions only
`ifndef PBPS_DEFS_VH
`define PBPS_DEFS_VH

// Register addresses
`define PBPS_ADDR_CTRL 4'h0
`define PBPS_ADDR_OVR_SEL 4'h1
`define PBPS_ADDR_REM_SEL 4'h2
`define PBPS_ADDR_STATUS 4'h3
`define PBPS_ADDR_ON_MASK 4'h4
`define PBPS_ADDR_OFF_MASK 4'h5
`define PBPS_ADDR_EVT_ON 4'h6
`define PBPS_ADDR_EVT_OFF 4'h7
`define PBPS_ADDR_EVT_TIME 4'h8
`define PBPS_ADDR_TIME_NOW 4'h9

// Control register fields
`define PBPS_CTRL_USED_LSB 0
`define PBPS_CTRL_USED_MSB 2
`define PBPS_CTRL_OVR_BIT 3

// Status register fields
`define PBPS_STAT_ACT_LSB 0
`define PBPS_STAT_EN_LSB 8
`define PBPS_STAT_LVL_LSB 16
`define PBPS_STAT_FAIL_LSB 24

// Bank counts and widths
`define PBPS_BANKS 8
`define PBPS_EVW 28

// Reset values and selection limit
`define PBPS_USED_RST 3'h0
`define PBPS_ACT_RST 3'h0
`define PBPS_EN_RST 8'h01
`define PBPS_SEL_NONE 4'h0
`define PBPS_SEL_MAX 4'h8
`define PBPS_ONEHOT_RST 8'h01
`define PBPS_MASK_RST 28'hFFFFFFF

`endif

// file: tb/pbps_req_model.sv
// Purpose: request sources that face the selector pins
// Assumes: commands arrive just after a rising edge
// Notes: pulses last four cycles, so the two-stage synchroniser sees them
`timescale 1ns/1ns
`default_nettype none
module pbps_req_model
(
  // Clock and commands
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] pulse_go_i,
  // Request pins
  output logic [7:0] req_o
);
  logic [7:0] pulse_reg = 8'h00;
  logic [1:0] cnt_reg = 2'h0;
  always @(posedge clk_i)
  begin
    if (pulse_go_i != 8'h00)
    begin
      pulse_reg <= pulse_go_i;
      cnt_reg <= 2'h3;
    end
    else if (cnt_reg != 2'h0)
      cnt_reg <= cnt_reg - 2'h1;
    else
      pulse_reg <= 8'h00;
  end
  assign req_o = level_i | pulse_reg;
endmodule // pbps_req_model
`default_nettype wire

// file: tb/pbps_selector_sva.sv
// Purpose: port assertions of the selector
// Assumes: bound to every pbps_selector
// Notes: mirrors control writes to know override and used count
`timescale 1ns/1ns
`default_nettype none
module pbps_selector_sva
(
  // Inputs of the design
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REQ_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  // Outputs of the design
  input wire logic [31:0] RDATA_O,
  input wire logic [2:0] ACTIVE_BANK_O,
  input wire logic [7:0] ACTIVE_ONEHOT_O,
  input wire logic [7:0] BANK_ENABLE_O,
  input wire logic [7:0] BANK_INIT_O
);
  logic ovr_reg;
  logic [2:0] used_reg;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  always @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ovr_reg <= 1'b0;
      used_reg <= 3'h0;
    end
    else if (WR_I && ADDR_I == 4'h0)
    begin
      ovr_reg <= WDATA_I[3];
      used_reg <= WDATA_I[2:0];
    end
  end
  a_onehot_match: assert property (ACTIVE_ONEHOT_O == 8'h01 << ACTIVE_BANK_O)
    else $error("one-hot and index differ");
  a_reset_bank1: assert property ($fell(RST_I) |-> ACTIVE_BANK_O == 3'h0 && BANK_ENABLE_O == 8'h01)
    else $error("reset state wrong");
  a_hold_quiet: assert property ((REQ_I == 8'h00 && !WR_I)[*6] |=> $stable(ACTIVE_BANK_O))
    else $error("bank moved without request");
  a_level_one_wins: assert property ((REQ_I[0] && !ovr_reg)[*6] |-> ACTIVE_BANK_O == 3'h0)
    else $error("bank 1 level not obeyed");
  a_override_holds: assert property ((ovr_reg && !WR_I)[*4] |=> $stable(ACTIVE_BANK_O))
    else $error("bank moved under override");
  a_read_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside read slot");
  a_enable_used: assert property ($stable(used_reg)[*3] |-> BANK_ENABLE_O == 8'hFF >> (3'h7 - used_reg))
    else $error("enable mask wrong");
  a_active_enabled: assert property ($stable(used_reg)[*4] |-> (ACTIVE_ONEHOT_O & ~BANK_ENABLE_O) == 8'h00)
    else $error("active bank not enabled");
  a_init_new_only: assert property (BANK_INIT_O != 8'h00 |-> ($past(BANK_ENABLE_O) & BANK_INIT_O) == 8'h00)
    else $error("init pulse on a bank already enabled");
endmodule // pbps_selector_sva
bind pbps_selector pbps_selector_sva pbps_selector_sva_inst (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .REQ_I(REQ_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .ACTIVE_BANK_O(ACTIVE_BANK_O), .ACTIVE_ONEHOT_O(ACTIVE_ONEHOT_O), .BANK_ENABLE_O(BANK_ENABLE_O),
  .BANK_INIT_O(BANK_INIT_O));
`default_nettype wire

// file: tb/pbps_selector_tb_top.sv
// Purpose: self-checking bench of the bank selector
// Assumes: pin requests take effect within eight cycles
// Notes: ends with random pulses under random used counts
`timescale 1ns/1ns
`default_nettype none
module pbps_selector_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] lvl = 8'h00;
  logic [7:0] go = 8'h00;
  logic [7:0] req;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] act;
  logic [7:0] en;
  logic [2:0] cur;
  logic [2:0] b;
  logic [2:0] u;
  logic [2:0] fail;
  logic [7:0] init;
  logic evt;
  logic [2:0] fail_seen = 3'h0;
  logic [7:0] init_seen = 8'h00;
  int n_evt = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  integer seed = 32'h8A99;
  pbps_req_model pbps_req_model_inst (.clk_i(clk), .level_i(lvl), .pulse_go_i(go), .req_o(req));
  pbps_selector pbps_selector_inst (.SYS_CLK_I(clk), .RST_I(rst), .REQ_I(req), .ADDR_I(addr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ACTIVE_BANK_O(act),
    .ACTIVE_ONEHOT_O(), .BANK_ENABLE_O(en), .BANK_INIT_O(init), .REQ_FAIL_O(fail), .EVENT_O(evt));
  // One-cycle flags are gathered so that later checks can look at them
  always @(posedge clk)
  begin
    if (!rst)
    begin
      fail_seen <= fail_seen | fail;
      init_seen <= init_seen | init;
      if (evt)
        n_evt <= n_evt + 1;
    end
  end
  initial
    forever #50 clk = ~clk;
  task automatic close_out;
  begin
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
  begin
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  end
  endtask
  task automatic pulse(input logic [7:0] m);
  begin
    go <= m;
    @(posedge clk);
    go <= 8'h00;
  end
  endtask
  // Pin path is about four cycles, eight leaves margin
  task automatic settle(input logic [2:0] exp);
  begin
    repeat (8) @(posedge clk);
    check(act, exp);
  end
  endtask
  // Shrinking the used count sends an out-of-range bank back to bank 1
  function automatic logic [2:0] pick(input logic [2:0] c, input logic [2:0] r, input logic [2:0] n);
    logic [2:0] k;
    k = (c > n) ? 3'h0 : c;
    return (r <= n) ? r : k;
  endfunction
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(en, 8'h01);
    pulse(8'h04);
    settle(3'h0);
    check(fail_seen, 3'h1);
    wr_reg(4'h0, 32'h7);
    pulse(8'h04);
    settle(3'h2);
    check(en, 8'hFF);
    check(init_seen, 8'hFE);
    rd <= 1'b1;
    addr <= 4'h3;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata[15:0], 16'hFF02);
    lvl <= 8'h50;
    settle(3'h4);
    check(fail_seen, 3'h5);
    pulse(8'h80);
    settle(3'h4);
    pulse(8'h02);
    settle(3'h1);
    lvl <= 8'h80;
    settle(3'h7);
    pulse(8'h08);
    settle(3'h3);
    lvl <= 8'h01;
    settle(3'h0);
    pulse(8'h02);
    settle(3'h0);
    lvl <= 8'h00;
    wr_reg(4'h0, 32'hF);
    wr_reg(4'h1, 32'h6);
    settle(3'h5);
    pulse(8'h01);
    settle(3'h5);
    check(fail_seen, 3'h7);
    wr_reg(4'h0, 32'h7);
    settle(3'h5);
    wr_reg(4'h0, 32'hF);
    lvl <= 8'h04;
    settle(3'h5);
    wr_reg(4'h0, 32'h7);
    settle(3'h2);
    wr_reg(4'h0, 32'hF);
    wr_reg(4'h2, 32'h6);
    settle(3'h2);
    lvl <= 8'h00;
    settle(3'h2);
    wr_reg(4'h2, 32'h4);
    settle(3'h3);
    wr_reg(4'h1, 32'h0);
    settle(3'h3);
    wr_reg(4'h0, 32'h7);
    wr_reg(4'h2, 32'h6);
    settle(3'h3);
    wr_reg(4'h0, 32'h1);
    settle(3'h0);
    check(n_evt != 0, 32'h1);
    cur = 3'h0;
    repeat (12)
    begin
      u = 3'($random(seed));
      b = 3'($random(seed));
      wr_reg(4'h0, {29'h0, u});
      pulse(8'h01 << b);
      cur = pick(cur, b, u);
      settle(cur);
      check(en, 8'hFF >> (3'h7 - u));
    end
    close_out;
  end
endmodule // pbps_selector_tb_top
`default_nettype wire
